/* ppc_ball_model.sv */
`timescale 1ns/10ps
module ppc_ball_model (
    // Pads
    input wire logic [7:0] col_pad_out,
    input wire logic [7:0] col_pad_oe,
    output logic [7:0]     ball_lvl
);
    // Board pull-up holds released balls high
    assign ball_lvl = (col_pad_out & col_pad_oe) | ~col_pad_oe;
endmodule // ppc_ball_model

/* ppc_cfg.svh */
`ifndef PPC_CFG_SVH
`define PPC_CFG_SVH

// ***************************************************************
// Register offsets
// ***************************************************************
`define PPC_ADDR_ROW_PULL_LOW   8'hAC
`define PPC_ADDR_ROW_PULL_HIGH  8'hAE
`define PPC_ADDR_COL_OD_ENABLE  8'hE0
`define PPC_ADDR_COL_OD_SOURCE  8'hE1

// ***************************************************************
// Reset values and fixed fields
// ***************************************************************
`define PPC_RST_ROW_PULL_LOW    16'h5555
`define PPC_RST_ROW_PULL_HIGH   8'h15
`define PPC_ROW_PULL_HIGH_RSVD  8'h5A
`define PPC_RST_COL_OD_ENABLE   8'h00
`define PPC_RST_COL_OD_SOURCE   8'h00

// ***************************************************************
// Pull field codes
// ***************************************************************
`define PPC_PULL_NONE           2'h0
`define PPC_PULL_DOWN           2'h1
`define PPC_PULL_UP_RB          2'h3

`endif

/* ppc_col_driver.sv */
`timescale 1ns/10ps
module ppc_col_driver (
    // Clock and reset
    input  wire logic clk,
    input  wire logic sys_rst,
    // Bank side
    ppc_pad_if.driver pads
);
    import ppc_pkg::*;

    typedef struct packed {
        logic [7:0] pad_out;
        logic [7:0] pad_oe;
    } ppc_drv_s;

    ppc_drv_s st_q;
    ppc_drv_s st_d;

    // ***************************************************************
    // Per-ball output stage
    // ***************************************************************
    always_comb begin
        st_d = st_q;
        for (int i = 0; i < 8; i++) begin
            st_d.pad_out[i] = pads.data_out[i];
            if (!pads.out_enable[i]) begin
                st_d.pad_oe[i] = 1'b0;
            end else if (!pads.od_enable[i]) begin
                st_d.pad_oe[i] = 1'b1;
            end else begin
                st_d.pad_oe[i] = (pads.data_out[i] == pads.od_source[i]);
            end
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign pads.pad_out = st_q.pad_out;
    assign pads.pad_oe  = st_q.pad_oe;

endmodule // ppc_col_driver

/* ppc_pad_cfg.sv */
// Overview of operation
// - Pull code 00 none, 01 down, 1x up
// - Pullup codes 2 and 3 read back 3
// - Row pull low at 0xAC, resets pulldown
// - Row pull high at 0xAE, reserved 0x5A
// - Open-drain enable at 0xE0, reset zero
// - Drive source at 0xE1, needs open drain
// - Source 0 drives low side only
// - Source 1 drives high side only
`include "ppc_cfg.svh"
`timescale 1ns/10ps
module ppc_pad_cfg (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        sys_rst,
    // Register port, one cycle write and read strobes
    input  wire logic [7:0]  reg_addr,
    input  wire logic        reg_wr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic        reg_rd,
    output logic [15:0]      reg_rdata,
    output logic             reg_hit,
    // Row ball pull controls
    output logic [11:0]      row_pullup_en,
    output logic [11:0]      row_pulldown_en,
    // Column ball output data from GPIO logic
    input  wire logic [7:0]  col_data_out,
    input  wire logic [7:0]  col_out_enable,
    // Column pads
    output logic [7:0]       col_pad_out,
    output logic [7:0]       col_pad_oe,
    output logic [7:0]       column_open_drain_bits,
    output logic [7:0]       column_drive_source_bits
);
    import ppc_pkg::*;

    ppc_state_s st_q;
    ppc_state_s st_d;
    ppc_pad_if  pads ();

    function automatic ppc_pull_t fold(input ppc_pull_t v);
        fold = v[1] ? `PPC_PULL_UP_RB : v;
    endfunction

    // ***************************************************************
    // Register writes and reads
    // ***************************************************************
    always_comb begin
        st_d = st_q;
        if (reg_wr) begin
            if (reg_addr == `PPC_ADDR_ROW_PULL_LOW) begin
                for (int i = 0; i < 8; i++) begin
                    st_d.row_pull_low[2*i +: 2] = fold(reg_wdata[2*i +: 2]);
                end
            end else if (reg_addr == `PPC_ADDR_ROW_PULL_HIGH) begin
                for (int i = 0; i < 4; i++) begin
                    st_d.row_pull_high[2*i +: 2] = fold(reg_wdata[2*i +: 2]);
                end
            end else if (reg_addr == `PPC_ADDR_COL_OD_ENABLE) begin
                st_d.col_od_enable = reg_wdata[7:0];
            end else if (reg_addr == `PPC_ADDR_COL_OD_SOURCE) begin
                st_d.col_od_source = reg_wdata[7:0];
            end
        end
        if (reg_rd) begin
            if (reg_addr == `PPC_ADDR_ROW_PULL_LOW) begin
                st_d.rdata = st_q.row_pull_low;
            end else if (reg_addr == `PPC_ADDR_ROW_PULL_HIGH) begin
                st_d.rdata = {`PPC_ROW_PULL_HIGH_RSVD, st_q.row_pull_high};
            end else if (reg_addr == `PPC_ADDR_COL_OD_ENABLE) begin
                st_d.rdata = {8'h00, st_q.col_od_enable};
            end else if (reg_addr == `PPC_ADDR_COL_OD_SOURCE) begin
                st_d.rdata = {8'h00, st_q.col_od_source};
            end else begin
                st_d.rdata = 16'h0000;
            end
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            st_q.row_pull_low  <= `PPC_RST_ROW_PULL_LOW;
            st_q.row_pull_high <= `PPC_RST_ROW_PULL_HIGH;
            st_q.col_od_enable <= `PPC_RST_COL_OD_ENABLE;
            st_q.col_od_source <= `PPC_RST_COL_OD_SOURCE;
            st_q.rdata         <= 16'h0000;
        end else begin
            st_q <= st_d;
        end
    end

    assign reg_rdata = st_q.rdata;
    assign reg_hit   = (reg_addr == `PPC_ADDR_ROW_PULL_LOW)
                     || (reg_addr == `PPC_ADDR_ROW_PULL_HIGH)
                     || (reg_addr == `PPC_ADDR_COL_OD_ENABLE)
                     || (reg_addr == `PPC_ADDR_COL_OD_SOURCE);

    // ***************************************************************
    // Pull decode per row ball
    // ***************************************************************
    logic [23:0] all_pull;
    assign all_pull = {st_q.row_pull_high, st_q.row_pull_low};

    genvar g;
    generate
        for (g = 0; g < 12; g++) begin : g_pull
            assign row_pullup_en[g]   = all_pull[2*g+1];
            assign row_pulldown_en[g] = (all_pull[2*g +: 2] == `PPC_PULL_DOWN);
        end
    endgenerate

    // ***************************************************************
    // Column output stage
    // ***************************************************************
    assign pads.od_enable  = st_q.col_od_enable;
    assign pads.od_source  = st_q.col_od_source;
    assign pads.data_out   = col_data_out;
    assign pads.out_enable = col_out_enable;

    ppc_col_driver u_drv (
        .clk     (clk),
        .sys_rst (sys_rst),
        .pads    (pads)
    );

    assign col_pad_out              = pads.pad_out;
    assign col_pad_oe               = pads.pad_oe;
    assign column_open_drain_bits   = st_q.col_od_enable;
    assign column_drive_source_bits = st_q.col_od_source;

endmodule // ppc_pad_cfg

/* ppc_pad_cfg_chk.sv */
`timescale 1ns/10ps
module ppc_pad_cfg_chk (
    // Clock, reset, register port
    input wire logic        clk,
    input wire logic        sys_rst,
    input wire logic [7:0]  reg_addr,
    input wire logic        reg_wr,
    input wire logic [15:0] reg_wdata,
    input wire logic        reg_rd,
    input wire logic [15:0] reg_rdata,
    input wire logic        reg_hit,
    // Pad controls
    input wire logic [11:0] row_pullup_en,
    input wire logic [11:0] row_pulldown_en,
    input wire logic [7:0]  col_data_out,
    input wire logic [7:0]  col_out_enable,
    input wire logic [7:0]  col_pad_out,
    input wire logic [7:0]  col_pad_oe,
    input wire logic [7:0]  column_open_drain_bits,
    input wire logic [7:0]  column_drive_source_bits
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    property p_dec; reg_wr && reg_addr == 8'hAC |=> row_pullup_en[7] == $past(reg_wdata[15])
        && row_pulldown_en[7] == ($past(reg_wdata[15:14]) == 2'h1); endproperty
    a_dec: assert property (p_dec) else $error("pull decode");
    property p_uprb; reg_rd && reg_addr == 8'hAC && row_pullup_en[0] |=> reg_rdata[1:0] == 2'h3;
    endproperty
    a_uprb: assert property (p_uprb) else $error("pullup readback");
    property p_hit; reg_hit == (reg_addr inside {8'hAC, 8'hAE, 8'hE0, 8'hE1}); endproperty
    a_hit: assert property (p_hit) else $error("address map");
    property p_rsvd; reg_rd && reg_addr == 8'hAE |=> reg_rdata[15:8] == 8'h5A; endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved byte");
    property p_ode; reg_wr && reg_addr == 8'hE0 |=> column_open_drain_bits == $past(reg_wdata[7:0]);
    endproperty
    a_ode: assert property (p_ode) else $error("od enable write");
    property p_ods; reg_wr && reg_addr == 8'hE1 |=> column_drive_source_bits == $past(reg_wdata[7:0]);
    endproperty
    a_ods: assert property (p_ods) else $error("od source write");
    property p_pp; column_open_drain_bits == 8'h00 |=> col_pad_oe == $past(col_out_enable)
        && col_pad_out == $past(col_data_out); endproperty
    a_pp: assert property (p_pp) else $error("push pull");
    property p_oden; column_open_drain_bits[7] |=> col_pad_oe[7] ==
        $past(col_out_enable[7] && col_data_out[7] == column_drive_source_bits[7]); endproperty
    a_oden: assert property (p_oden) else $error("od release");
    property p_odlv; column_open_drain_bits[7] |=> !col_pad_oe[7]
        || col_pad_out[7] == $past(column_drive_source_bits[7]); endproperty
    a_odlv: assert property (p_odlv) else $error("od level");
endmodule // ppc_pad_cfg_chk
bind ppc_pad_cfg ppc_pad_cfg_chk u_chk (.*);

/* ppc_pad_cfg_test.sv */
`timescale 1ns/10ps
module ppc_pad_cfg_test;
    logic        clk = 0, sys_rst = 1, reg_wr = 0, reg_rd = 0;
    logic [7:0]  reg_addr = 0, col_data_out = 0, col_out_enable = 0, eoe, eout;
    logic [15:0] reg_wdata = 0;
    wire [15:0]  reg_rdata;
    wire [11:0]  row_pullup_en, row_pulldown_en;
    wire [7:0]   col_pad_out, col_pad_oe, ball_lvl;
    wire         reg_hit;
    wire [7:0]   column_open_drain_bits, column_drive_source_bits;
    int          bad_count = 0, comparisons = 0;
    ppc_pad_cfg u_dut (.*);
    ppc_ball_model u_balls (.*);
    initial forever #2.5 clk = ~clk;
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic acc(input logic w, input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_wr <= w;
        reg_rd <= !w;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        #1;
        if (!w) chk(reg_rdata, d);
    endtask
    task automatic report_and_stop;
        if (bad_count == 0 && comparisons > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        repeat (4000) @(posedge clk);
        bad_count++;
        report_and_stop;
    end
    // *****
    // Main sequence
    // *****
    initial begin
        repeat (20) @(posedge clk);
        sys_rst <= 1'b0;
        acc(0, 8'hAC, 16'h5555);
        acc(0, 8'hAE, 16'h5A15);
        acc(0, 8'hE0, 16'h0000);
        acc(0, 8'hE1, 16'h0000);
        chk({column_open_drain_bits, column_drive_source_bits}, 16'h0000);
        chk({15'h0000, reg_hit}, 16'h0001);
        acc(0, 8'h00, 16'h0000);
        chk({15'h0000, reg_hit}, 16'h0000);
        chk({4'h0, row_pulldown_en}, 16'h07FF);
        chk({4'h0, row_pullup_en}, 16'h0000);
        for (int c = 0; c < 4; c++) begin
            acc(1, 8'hAC, {8{c[1:0]}});
            acc(0, 8'hAC, {8{c == 2 ? 2'h3 : c[1:0]}});
            chk({row_pullup_en[7:0], row_pulldown_en[7:0]}, {{8{c[1]}}, {8{c == 1}}});
        end
        acc(1, 8'hAE, 16'hFFC6);
        acc(0, 8'hAE, 16'h5AC7);
        chk({8'h00, row_pullup_en[11:8], row_pulldown_en[11:8]}, 16'h0092);
        acc(1, 8'hE0, 16'hFFF0);
        acc(1, 8'hE1, 16'h00CC);
        acc(0, 8'hE0, 16'h00F0);
        acc(0, 8'hE1, 16'h00CC);
        chk({column_open_drain_bits, column_drive_source_bits}, 16'hF0CC);
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            col_data_out <= 8'h5A ^ {8{i[0]}};
            col_out_enable <= i[1] ? 8'h3C : 8'hFF;
            repeat (2) @(posedge clk);
            #1;
            // Low nibble push-pull, high nibble open drain
            eoe = col_out_enable & (8'h0F | ~(col_data_out ^ 8'hCC));
            eout = 8'hC0 | (col_data_out & 8'h0F);
            chk({col_pad_oe, ball_lvl}, {eoe, (eout & eoe) | ~eoe});
        end
        report_and_stop;
    end
endmodule // ppc_pad_cfg_test

/* ppc_pad_if.sv */
`timescale 1ns/10ps
interface ppc_pad_if;
    logic [7:0] od_enable;
    logic [7:0] od_source;
    logic [7:0] data_out;
    logic [7:0] out_enable;
    logic [7:0] pad_out;
    logic [7:0] pad_oe;

    modport bank (output od_enable, output od_source, output data_out, output out_enable,
                  input pad_out, input pad_oe);
    modport driver (input od_enable, input od_source, input data_out, input out_enable,
                    output pad_out, output pad_oe);
endinterface

/* ppc_pkg.sv */
package ppc_pkg;

    typedef logic [1:0] ppc_pull_t;

    // All register state of the bank
    typedef struct packed {
        logic [15:0] row_pull_low;
        logic [7:0]  row_pull_high;
        logic [7:0]  col_od_enable;
        logic [7:0]  col_od_source;
        logic [15:0] rdata;
    } ppc_state_s;

    // Per-ball pad control
    typedef struct packed {
        logic pullup_en;
        logic pulldown_en;
    } ppc_pull_s;

endpackage
